//--- rtl/pfr_sequencer.sv
// Power-fail reset sequencer: park, controller reset and peripheral reset outputs
`timescale 1ns/10ps
`default_nettype none
`include "pfr_defines.svh"

module pfr_sequencer #(
  parameter int unsigned HOLD_CYC = `PFR_HOLD_MIN_CYC,
  parameter int unsigned DLY_CYC  = `PFR_WARN_DELAY_CYC,
  parameter int unsigned LOW_CYC  = `PFR_PG_LOW_MIN_CYC,
  parameter int unsigned QUAL_CYC = `PFR_PG_QUAL_CYC
) (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst_n,
  input  wire logic                   i_power_on_sense,
  input  wire logic                   i_supply_good_warning,
  input  wire logic                   i_park_done,
  input  wire logic                   i_internal_reset,
  input  wire logic                   i_lamp_strike_reset,
  input  wire logic                   i_psel,
  input  wire logic                   i_penable,
  input  wire logic                   i_pwrite,
  input  wire logic [`PFR_ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]            i_pwdata,
  output logic                        o_pready,
  output logic [31:0]                 o_prdata,
  output logic                        o_pslverr,
  output logic                        o_ctrl_reset,
  output logic                        o_mirror_array_park_req,
  output logic                        o_general_reset_out_n,
  output logic                        o_motor_reset_out_n
);

  typedef logic [`PFR_HOLD_CNT_W-1:0]  hold_type;
  typedef logic [`PFR_SHORT_CNT_W-1:0] dly_type;

  localparam pfr_pkg::pfr_top_state_type RST_ST = '{
    seq:        pfr_pkg::PFR_SEQ_HOLD,
    ctrl_reset: 1'b1,
    por_latch:  2'b11,
    hold:       {hold_type'(HOLD_CYC), hold_type'(HOLD_CYC)},
    default:    '0
  };

  // ---------------------------------------------------------------
  // Reset and supply-good filter
  // ---------------------------------------------------------------
  // Power-on sense low clears everything at once, clock or not
  logic rst_n;
  assign rst_n = i_rst_n & i_power_on_sense;

  logic f_warn;
  logic f_good;

  pfr_pg_filter #(
    .LOW_CYC  (LOW_CYC),
    .QUAL_CYC (QUAL_CYC)
  ) u_filter (
    .i_clk                 (i_clk),
    .i_rst_n               (rst_n),
    .i_supply_good_warning (i_supply_good_warning),
    .o_warn                (f_warn),
    .o_good                (f_good)
  );

  pfr_pkg::pfr_top_state_type st;
  pfr_pkg::pfr_top_state_type next_st;

  // ---------------------------------------------------------------
  // Register read images
  // ---------------------------------------------------------------
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;

  always_comb begin
    ctrl_word                     = `PFR_CTRL_RST;
    ctrl_word[`PFR_GEN_FORCE_BIT] = st.ctrl.gen_force;
    ctrl_word[`PFR_MOT_FORCE_BIT] = st.ctrl.mot_force;
    ctrl_word[`PFR_MOT_WARN_BIT]  = st.ctrl.mot_warn_en;
    ctrl_word[`PFR_MOT_LAMP_BIT]  = st.ctrl.mot_lamp_en;
    stat_word                                   = '0;
    stat_word[`PFR_ST_GEN_OUT_BIT]              = st.out_n[0];
    stat_word[`PFR_ST_MOT_OUT_BIT]              = st.out_n[1];
    stat_word[`PFR_ST_GOOD_BIT]                 = f_good;
    stat_word[`PFR_ST_CRST_BIT]                 = st.ctrl_reset;
    stat_word[`PFR_ST_PARK_BIT]                 = st.park_req;
    stat_word[`PFR_ST_GEN_POR_BIT]              = st.por_latch[0];
    stat_word[`PFR_ST_MOT_POR_BIT]              = st.por_latch[1];
    stat_word[`PFR_ST_SEQ_LSB+1:`PFR_ST_SEQ_LSB] = st.seq;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic       soft_req;
  logic       seq_trig;
  logic [1:0] trig;
  logic [1:0] force_low;

  always_comb begin
    next_st   = st;
    soft_req  = 1'b0;
    seq_trig  = 1'b0;
    trig      = '0;
    force_low = '0;

    // APB: one wait state; data and error are registered on the same edge that ready rises
    next_st.apb.pready = 1'b0;
    if (i_psel && i_penable && !st.apb.pready) begin
      next_st.apb.pready  = 1'b1;
      next_st.apb.pslverr = 1'b0;
      if (i_paddr == `PFR_CTRL_OFS) begin
        next_st.apb.prdata = ctrl_word;
      end else if (i_paddr == `PFR_STAT_OFS) begin
        next_st.apb.prdata = stat_word;
      end else begin
        next_st.apb.prdata  = '0;
        next_st.apb.pslverr = 1'b1;
      end
    end else if (i_psel && i_penable && st.apb.pready && i_pwrite &&
                 i_paddr == `PFR_CTRL_OFS) begin
      // Write lands on the same edge the master sees ready
      next_st.ctrl.gen_force   = i_pwdata[`PFR_GEN_FORCE_BIT];
      next_st.ctrl.mot_force   = i_pwdata[`PFR_MOT_FORCE_BIT];
      next_st.ctrl.mot_warn_en = i_pwdata[`PFR_MOT_WARN_BIT];
      next_st.ctrl.mot_lamp_en = i_pwdata[`PFR_MOT_LAMP_BIT];
      if (i_pwdata[`PFR_GEN_REL_BIT]) begin
        next_st.por_latch[0] = 1'b0;
      end
      if (i_pwdata[`PFR_MOT_REL_BIT]) begin
        next_st.por_latch[1] = 1'b0;
      end
      soft_req = i_pwdata[`PFR_SOFT_RST_BIT];
    end

    // Park and controller-reset sequence
    case (st.seq)
      pfr_pkg::PFR_SEQ_IDLE: begin
        next_st.ctrl_reset = 1'b0;
        if (f_warn) begin
          next_st.seq       = pfr_pkg::PFR_SEQ_DETECT;
          next_st.via_pg    = 1'b1;
          next_st.dly       = '0;
          next_st.park_req  = 1'b1;
          next_st.park_seen = 1'b0;
        end else if (i_internal_reset || soft_req) begin
          next_st.seq       = pfr_pkg::PFR_SEQ_DETECT;
          next_st.via_pg    = 1'b0;
          next_st.dly       = '0;
          next_st.park_seen = 1'b1;
        end
      end
      pfr_pkg::PFR_SEQ_DETECT: begin
        // A warning landing on an internal reset still needs the park
        if (f_warn && !st.via_pg) begin
          next_st.via_pg    = 1'b1;
          next_st.park_req  = 1'b1;
          next_st.park_seen = 1'b0;
        end
        if (st.dly != dly_type'(DLY_CYC)) begin
          next_st.dly = st.dly + 1'b1;
          seq_trig    = (st.dly == dly_type'(DLY_CYC - 1));
        end
        if (st.park_req && i_park_done) begin
          next_st.park_req  = 1'b0;
          next_st.park_seen = 1'b1;
        end
        if (st.dly == dly_type'(DLY_CYC) && st.park_seen && !(f_warn && !st.via_pg)) begin
          next_st.seq        = pfr_pkg::PFR_SEQ_HOLD;
          next_st.ctrl_reset = 1'b1;
        end
      end
      pfr_pkg::PFR_SEQ_HOLD: begin
        next_st.ctrl_reset = 1'b1;
        next_st.park_req   = 1'b0;
        if (f_good) begin
          next_st.seq        = pfr_pkg::PFR_SEQ_IDLE;
          next_st.ctrl_reset = 1'b0;
        end
      end
      default: begin
        next_st.seq        = pfr_pkg::PFR_SEQ_HOLD;
        next_st.ctrl_reset = 1'b1;
      end
    endcase

    // Reset outputs: index 0 general, index 1 motor
    trig[0]      = seq_trig;
    trig[1]      = (seq_trig && st.ctrl.mot_warn_en) ||
                   (i_lamp_strike_reset && st.ctrl.mot_lamp_en);
    force_low[0] = st.ctrl.gen_force;
    force_low[1] = st.ctrl.mot_force;
    for (int ch = 0; ch < 2; ch++) begin
      // Forcing reloads the timer too, so release is never shorter than the minimum
      if (trig[ch] || force_low[ch]) begin
        next_st.hold[ch] = hold_type'(HOLD_CYC);
      end else if (st.hold[ch] != '0) begin
        next_st.hold[ch] = st.hold[ch] - 1'b1;
      end
      next_st.out_n[ch] = !(next_st.por_latch[ch] || force_low[ch] || trig[ch] ||
                            st.hold[ch] != '0);
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= RST_ST;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_pready                = st.apb.pready;
  assign o_prdata                = st.apb.prdata;
  assign o_pslverr               = st.apb.pslverr;
  assign o_ctrl_reset            = st.ctrl_reset;
  assign o_mirror_array_park_req = st.park_req;
  assign o_general_reset_out_n   = st.out_n[0];
  assign o_motor_reset_out_n     = st.out_n[1];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_park_first;
    @(posedge i_clk) disable iff (!rst_n)
      $rose(st.ctrl_reset) && $past(st.via_pg) |-> $past(st.park_seen) && !st.park_req;
  endproperty
  a_park_first: assert property (p_park_first)
    else $error("controller reset before mirror array park finished");

  property p_hold_while_low;
    @(posedge i_clk) disable iff (!rst_n)
      st.ctrl_reset && !f_good |=> st.ctrl_reset;
  endproperty
  a_hold_while_low: assert property (p_hold_while_low)
    else $error("controller left reset while supply good low");

  property p_leave_qualified;
    @(posedge i_clk) disable iff (!rst_n)
      $fell(st.ctrl_reset) |-> $past(f_good);
  endproperty
  a_leave_qualified: assert property (p_leave_qualified)
    else $error("controller left reset without qualified supply good");

  property p_por_immediate;
    @(posedge i_clk) disable iff (!i_rst_n)
      !i_power_on_sense |-> !o_general_reset_out_n && !o_motor_reset_out_n;
  endproperty
  a_por_immediate: assert property (p_por_immediate)
    else $error("reset output high while power-on sense low");

  property p_gen_latch;
    @(posedge i_clk) disable iff (!rst_n)
      st.por_latch[0] |-> !o_general_reset_out_n;
  endproperty
  a_gen_latch: assert property (p_gen_latch)
    else $error("general reset released before software release");

  // Age of the detect state kept apart from st.dly; saturates so a long park cannot wrap it
  logic [`PFR_SHORT_CNT_W-1:0] chk_age;
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      chk_age <= '0;
    end else if (st.seq != pfr_pkg::PFR_SEQ_DETECT) begin
      chk_age <= '0;
    end else if (chk_age != '1) begin
      chk_age <= chk_age + 1'b1;
    end
  end

  property p_warn_delay;
    @(posedge i_clk) disable iff (!rst_n)
      st.seq == pfr_pkg::PFR_SEQ_DETECT && chk_age == dly_type'(DLY_CYC) |->
        !o_general_reset_out_n;
  endproperty
  a_warn_delay: assert property (p_warn_delay)
    else $error("general reset not asserted at warning delay");

  property p_min_hold;
    @(posedge i_clk) disable iff (!rst_n)
      !o_general_reset_out_n && st.hold[0] > hold_type'(1) |=> !o_general_reset_out_n;
  endproperty
  a_min_hold: assert property (p_min_hold)
    else $error("general reset released before minimum hold");

  property p_force;
    @(posedge i_clk) disable iff (!rst_n)
      st.ctrl.gen_force || st.ctrl.mot_force |=>
        (!o_general_reset_out_n || !$past(st.ctrl.gen_force)) &&
        (!o_motor_reset_out_n || !$past(st.ctrl.mot_force));
  endproperty
  a_force: assert property (p_force)
    else $error("forced reset output not low");

  property p_mot_latch;
    @(posedge i_clk) disable iff (!rst_n)
      st.por_latch[1] |-> !o_motor_reset_out_n;
  endproperty
  a_mot_latch: assert property (p_mot_latch)
    else $error("motor reset released before software release");

  property p_mot_warn;
    @(posedge i_clk) disable iff (!rst_n)
      seq_trig && st.ctrl.mot_warn_en |=> !o_motor_reset_out_n [*2];
  endproperty
  a_mot_warn: assert property (p_mot_warn)
    else $error("motor reset missed on warning with option set");

  property p_lamp;
    @(posedge i_clk) disable iff (!rst_n)
      i_lamp_strike_reset && st.ctrl.mot_lamp_en |=> !o_motor_reset_out_n;
  endproperty
  a_lamp: assert property (p_lamp)
    else $error("motor reset missed on lamp strike");

endmodule // pfr_sequencer
`default_nettype wire

//--- rtl/pfr_defines.svh
// Offsets, field positions, reset values and timing counts of the power-fail reset block
`ifndef PFR_DEFINES_SVH
`define PFR_DEFINES_SVH

// ---------------------------------------------------------------
// Clock and timing
// ---------------------------------------------------------------
`define PFR_CLK_PERIOD_NS  4
`define PFR_WARN_DELAY_NS  5000
`define PFR_WARN_DELAY_CYC (`PFR_WARN_DELAY_NS / `PFR_CLK_PERIOD_NS)
`define PFR_HOLD_MIN_NS    2000000
`define PFR_HOLD_MIN_CYC   ((`PFR_HOLD_MIN_NS + `PFR_CLK_PERIOD_NS - 1) / `PFR_CLK_PERIOD_NS)
`define PFR_PG_LOW_MIN_NS  1000
`define PFR_PG_LOW_MIN_CYC ((`PFR_PG_LOW_MIN_NS + `PFR_CLK_PERIOD_NS - 1) / `PFR_CLK_PERIOD_NS)
`define PFR_PG_QUAL_NS     10000
`define PFR_PG_QUAL_CYC    ((`PFR_PG_QUAL_NS + `PFR_CLK_PERIOD_NS - 1) / `PFR_CLK_PERIOD_NS)

// ---------------------------------------------------------------
// Counter widths
// ---------------------------------------------------------------
`define PFR_HOLD_CNT_W 20
`define PFR_SHORT_CNT_W 12

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define PFR_ADDR_W    12
`define PFR_CTRL_OFS  12'h000
`define PFR_STAT_OFS  12'h004
`define PFR_CTRL_RST  32'h0000_0000

// Control word fields
`define PFR_GEN_REL_BIT   0
`define PFR_MOT_REL_BIT   1
`define PFR_GEN_FORCE_BIT 2
`define PFR_MOT_FORCE_BIT 3
`define PFR_MOT_WARN_BIT  4
`define PFR_MOT_LAMP_BIT  5
`define PFR_SOFT_RST_BIT  6

// Status word fields
`define PFR_ST_GEN_OUT_BIT  0
`define PFR_ST_MOT_OUT_BIT  1
`define PFR_ST_GOOD_BIT     2
`define PFR_ST_CRST_BIT     3
`define PFR_ST_PARK_BIT     4
`define PFR_ST_GEN_POR_BIT  5
`define PFR_ST_MOT_POR_BIT  6
`define PFR_ST_SEQ_LSB      8

`endif

//--- rtl/pfr_pkg.sv
// Types shared by the power-fail reset sequencer
`include "pfr_defines.svh"

package pfr_pkg;

  typedef enum logic [1:0] {
    PFR_SEQ_IDLE,
    PFR_SEQ_DETECT,
    PFR_SEQ_HOLD
  } pfr_seq_type;

  typedef struct packed {
    logic mot_lamp_en;
    logic mot_warn_en;
    logic mot_force;
    logic gen_force;
  } pfr_ctrl_type;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } pfr_apb_rsp_type;

  typedef struct packed {
    pfr_seq_type                            seq;
    logic                                   via_pg;
    logic [`PFR_SHORT_CNT_W-1:0]            dly;
    logic                                   park_req;
    logic                                   park_seen;
    logic                                   ctrl_reset;
    pfr_ctrl_type                           ctrl;
    logic [1:0]                             por_latch;
    logic [1:0][`PFR_HOLD_CNT_W-1:0]        hold;
    logic [1:0]                             out_n;
    pfr_apb_rsp_type                        apb;
  } pfr_top_state_type;

  typedef struct packed {
    logic                        sync1;
    logic                        sync2;
    logic [`PFR_SHORT_CNT_W-1:0] low_cnt;
    logic [`PFR_SHORT_CNT_W-1:0] high_cnt;
    logic                        warned;
    logic                        warn;
    logic                        good;
  } pfr_filt_state_type;

endpackage

//--- rtl/pfr_pg_filter.sv
// Supply-good synchroniser, glitch filter and qualification timer
`timescale 1ns/10ps
`default_nettype none
`include "pfr_defines.svh"

module pfr_pg_filter #(
  parameter int unsigned LOW_CYC  = `PFR_PG_LOW_MIN_CYC,
  parameter int unsigned QUAL_CYC = `PFR_PG_QUAL_CYC
) (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_supply_good_warning,
  output logic      o_warn,
  output logic      o_good
);

  typedef logic [`PFR_SHORT_CNT_W-1:0] cnt_type;

  pfr_pkg::pfr_filt_state_type st;
  pfr_pkg::pfr_filt_state_type next_st;

  // ---------------------------------------------------------------
  // Filter
  // ---------------------------------------------------------------
  always_comb begin
    next_st       = st;
    next_st.sync1 = i_supply_good_warning;
    next_st.sync2 = st.sync1;
    next_st.warn  = 1'b0;
    if (st.sync2) begin
      next_st.low_cnt = '0;
      next_st.warned  = 1'b0;
      // Any low restarts this count, so qualification needs a clean high run
      if (st.high_cnt != cnt_type'(QUAL_CYC)) begin
        next_st.high_cnt = st.high_cnt + 1'b1;
      end else begin
        next_st.good = 1'b1;
      end
    end else begin
      next_st.high_cnt = '0;
      if (st.low_cnt != cnt_type'(LOW_CYC)) begin
        next_st.low_cnt = st.low_cnt + 1'b1;
      end else if (!st.warned) begin
        next_st.warned = 1'b1;
        next_st.warn   = 1'b1;
        next_st.good   = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_warn = st.warn;
  assign o_good = st.good;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_glitch_reject;
    @(posedge i_clk) disable iff (!i_rst_n)
      $rose(st.warn) |-> $past(st.low_cnt) == cnt_type'(LOW_CYC) && $past(!st.sync2);
  endproperty
  a_glitch_reject: assert property (p_glitch_reject)
    else $error("warning raised before minimum low time");

  property p_qualify;
    @(posedge i_clk) disable iff (!i_rst_n)
      $rose(st.good) |-> $past(st.high_cnt) == cnt_type'(QUAL_CYC) && $past(st.sync2);
  endproperty
  a_qualify: assert property (p_qualify)
    else $error("supply good qualified too early");

endmodule // pfr_pg_filter
`default_nettype wire

//--- sim/pfr_monitor_model.sv
// Model of the external voltage monitor and the mirror array park handshake
`timescale 1ns/10ps
`default_nettype none

module pfr_monitor_model #(
  parameter int unsigned PARK_LAT = 3
) (
  input  wire logic i_clk,
  input  wire logic i_park_req,
  output logic      o_power_on_sense,
  output logic      o_supply_good_warning,
  output logic      o_park_done
);
  int unsigned park_cnt;

  initial begin
    o_power_on_sense      = 1'b0;
    o_supply_good_warning = 1'b0;
    o_park_done           = 1'b0;
    park_cnt              = 0;
  end

  // Park takes a few cycles; done drops one clock after the request, never left standing
  always @(posedge i_clk) begin
    park_cnt    <= i_park_req ? park_cnt + 1 : 0;
    o_park_done <= i_park_req && park_cnt >= PARK_LAT;
  end

  // Supplies come up with sense first, good follows
  task power_up();
    o_power_on_sense <= 1'b1;
    repeat (3) @(posedge i_clk);
    o_supply_good_warning <= 1'b1;
  endtask

  // Sense is left high for as long as good is low
  task good_low();
    o_supply_good_warning <= 1'b0;
  endtask

  task good_high();
    o_supply_good_warning <= 1'b1;
  endtask

  task warn(input int cycles);
    good_low();
    repeat (cycles) @(posedge i_clk);
    good_high();
  endtask

  // Sense may only drop once good has already fallen
  task power_cut();
    o_supply_good_warning <= 1'b0;
    repeat (4) @(posedge i_clk);
    o_power_on_sense <= 1'b0;
  endtask
endmodule // pfr_monitor_model

`default_nettype wire

//--- sim/testbench.sv
// Testbench of the power-fail reset sequencer
`timescale 1ns/10ps
`default_nettype none
`include "pfr_defines.svh"

module testbench;
  localparam int HOLD = 200;
  localparam int DLY  = 1250;
  localparam int LOW  = 8;
  localparam int QUAL = 16;

  logic        clk, rst_n, int_rst, lamp, psel, penable, pwrite, pready, pslverr;
  logic        pos, good, park_done, ctrl_rst, park_req, gen_n, mot_n;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  obs;
  int          n_errors, comparisons, cyc, t, tr;

  assign obs = {ctrl_rst, park_req, gen_n, mot_n};

  pfr_monitor_model mon (.i_clk(clk), .i_park_req(park_req), .o_power_on_sense(pos),
    .o_supply_good_warning(good), .o_park_done(park_done));

  // The warning delay keeps its full length; only hold and filter counts shrink
  pfr_sequencer #(.HOLD_CYC(HOLD), .DLY_CYC(DLY), .LOW_CYC(LOW), .QUAL_CYC(QUAL)) uut (
    .i_clk(clk), .i_rst_n(rst_n), .i_power_on_sense(pos), .i_supply_good_warning(good),
    .i_park_done(park_done), .i_internal_reset(int_rst), .i_lamp_strike_reset(lamp),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
    .o_ctrl_reset(ctrl_rst), .o_mirror_array_park_req(park_req),
    .o_general_reset_out_n(gen_n), .o_motor_reset_out_n(mot_n));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) cyc <= cyc + 1;

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task tally_and_finish();
    $display("Comparisons %0d, errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Waits for one observed output; a required wait that runs out ends the run
  task wt(input int b, input logic v, input int max, input bit must);
    int k;
    k = 0;
    while (obs[b] !== v && k < max) begin
      @(posedge clk);
      k++;
    end
    if (must && k >= max) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, obs[b], v);
      tally_and_finish();
    end
  endtask

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, pready, 1'b1);
      tally_and_finish();
    end
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    // One idle edge, so a following call never reassigns psel in this time step
    @(posedge clk);
  endtask

  initial begin
    #400000;
    n_errors++;
    $display("ERROR at %0t: got %h expected %h", $time, cyc, 0);
    tally_and_finish();
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    {rst_n, int_rst, lamp, psel, penable, pwrite, paddr, pwdata} = '0;
    {cyc, n_errors, comparisons} = '0;
    repeat (3) @(posedge clk);
    #1 chk(obs, 4'b1000);
    @(posedge clk);
    rst_n <= 1'b1;
    tr = cyc;
    mon.power_up();
    t = cyc;
    wt(3, 1'b0, QUAL + 40, 1'b1);
    chk(cyc - t >= QUAL, 1);
    apb(1'b0, `PFR_STAT_OFS, 0);
    chk(q[2:0], 3'b100);
    apb(1'b1, `PFR_CTRL_OFS, 32'h03);
    wt(1, 1'b1, HOLD + 40, 1'b1);
    chk(cyc - tr >= HOLD, 1);
    chk(obs[1:0], 2'b11);
    apb(1'b0, 12'h008, 0);
    chk(q, 0);
    chk(pslverr, 1);
    // Too short a low on supply good starts nothing
    mon.warn(LOW);
    wt(2, 1'b1, 40, 1'b0);
    chk(obs[3:2], 2'b00);
    // Sustained warning with the motor option on
    apb(1'b1, `PFR_CTRL_OFS, 32'h10);
    mon.good_low();
    wt(2, 1'b1, LOW + 20, 1'b1);
    chk(ctrl_rst, 0);
    t = cyc;
    wt(1, 1'b0, DLY + 40, 1'b1);
    chk(cyc - t >= DLY - 20, 1);
    chk(mot_n, 0);
    t = cyc;
    wt(3, 1'b1, 40, 1'b1);
    repeat (600) @(posedge clk);
    chk(ctrl_rst, 1);
    mon.good_high();
    tr = cyc;
    wt(3, 1'b0, QUAL + 40, 1'b1);
    chk(cyc - tr >= QUAL, 1);
    apb(1'b1, `PFR_CTRL_OFS, 32'h13);
    wt(1, 1'b1, HOLD + 40, 1'b1);
    chk(cyc - t >= HOLD, 1);
    wt(0, 1'b1, 40, 1'b1);
    // Software force on the general output alone
    apb(1'b1, `PFR_CTRL_OFS, 32'h04);
    wt(1, 1'b0, 10, 1'b1);
    t = cyc;
    chk(mot_n, 1);
    apb(1'b1, `PFR_CTRL_OFS, 32'h01);
    wt(1, 1'b1, HOLD + 40, 1'b1);
    chk(cyc - t >= HOLD, 1);
    // Internal reset with the motor option off
    int_rst <= 1'b1;
    @(posedge clk);
    int_rst <= 1'b0;
    t = cyc;
    wt(1, 1'b0, DLY + 40, 1'b1);
    chk(cyc - t >= DLY - 20, 1);
    chk(mot_n, 1);
    apb(1'b1, `PFR_CTRL_OFS, 32'h01);
    wt(1, 1'b1, HOLD + 40, 1'b1);
    // Software-requested internal reset through the control word
    apb(1'b1, `PFR_CTRL_OFS, 32'h41);
    t = cyc;
    wt(1, 1'b0, DLY + 40, 1'b1);
    chk(cyc - t >= DLY - 20, 1);
    chk(mot_n, 1);
    apb(1'b1, `PFR_CTRL_OFS, 32'h01);
    wt(1, 1'b1, HOLD + 40, 1'b1);
    // Lamp strike reaches the motor output when enabled
    apb(1'b1, `PFR_CTRL_OFS, 32'h20);
    lamp <= 1'b1;
    @(posedge clk);
    lamp <= 1'b0;
    wt(0, 1'b0, DLY + 40, 1'b1);
    apb(1'b1, `PFR_CTRL_OFS, 32'h03);
    wt(0, 1'b1, HOLD + DLY, 1'b1);
    wt(1, 1'b1, HOLD + DLY, 1'b1);
    // Power cut drops both outputs without a clock edge
    mon.power_cut();
    #1 chk(obs, 4'b1000);
    @(posedge clk);
    mon.power_up();
    repeat (HOLD + 40) @(posedge clk);
    chk(obs[1:0], 2'b00);
    tally_and_finish();
  end
endmodule // testbench

`default_nettype wire
